// ---- common/global_reset_consts.vh ----
`ifndef GLOBAL_RESET_CONSTS_VH
`define GLOBAL_RESET_CONSTS_VH
`define RELEASE_CYCLE_DEFAULT 4'h4
`define CYC_W                 4
`define ST_CONFIG             2'h0
`define ST_STARTUP            2'h1
`define ST_USER               2'h2
`define BUSY_RESET            1'h1
`define SYNC_RESET            1'h0
`define CYC_ZERO              4'h0
`define CYC_STEP              4'h1
`define NET_HELD              1'h1
`define GATE_INIT             1'h0
`define READY_INIT            1'h0
`endif

// ---- logic/global_reset_tristate_control.v ----
`timescale 1ns/1ns
`include "global_reset_consts.vh"
module global_reset_tristate_control #(
  parameter              NUM_DIES  = 2,
  parameter              SLICE_W   = 4,
  parameter [`CYC_W-1:0] REL_CYCLE = `RELEASE_CYCLE_DEFAULT
) (
  // clock and reset
  input  wire                  sys_clk_i,
  input  wire                  reset_i,
  // configuration sequencer
  input  wire                  config_busy_i,
  // user sources after configuration
  input  wire                  user_set_reset_i,
  input  wire                  user_high_z_i,
  // gate-mode latches of one slice
  input  wire [SLICE_W-1:0]    latch_data_input_i,
  input  wire                  set_reset_input_i,
  input  wire [SLICE_W-1:0]    gate_is_or_i,
  // outputs
  output reg  [NUM_DIES-1:0]   global_set_reset_net_o,
  output reg  [NUM_DIES-1:0]   global_high_z_net_o,
  output reg  [SLICE_W-1:0]    gate_q_o,
  output reg                   user_ready_o
);

  localparam [1:0] S_CONFIG  = `ST_CONFIG;
  localparam [1:0] S_STARTUP = `ST_STARTUP;
  localparam [1:0] S_USER    = `ST_USER;

  // synchronisers: only the second flop is read by logic
  reg                 busy_meta_reg;
  reg                 busy_sync_reg;
  reg                 usr_sr_meta_reg;
  reg                 usr_sr_sync_reg;
  reg                 usr_hz_meta_reg;
  reg                 usr_hz_sync_reg;
  reg                 slice_sr_meta_reg;
  reg                 slice_sr_sync_reg;
  reg  [SLICE_W-1:0]  data_meta_reg;
  reg  [SLICE_W-1:0]  data_sync_reg;

  // sequencer
  reg  [1:0]          state_reg;
  reg  [1:0]          state_next;
  reg  [`CYC_W-1:0]   cyc_reg;
  reg  [`CYC_W-1:0]   cyc_next;
  wire                in_config;
  wire                in_startup;
  wire                in_user;
  wire                release_hit;

  // net sources
  reg                 net_sr_src;
  reg                 net_hz_src;

  // gate lanes
  wire [SLICE_W-1:0]  and_inv_out;
  wire [SLICE_W-1:0]  or_out;
  reg  [SLICE_W-1:0]  gate_next;
  reg  [SLICE_W-1:0]  gate_q_next;

  // output stage next values
  reg  [NUM_DIES-1:0] sr_net_next;
  reg  [NUM_DIES-1:0] hz_net_next;
  reg                 ready_next;
  integer             die_idx;
  integer             bit_idx;
  genvar              lane;

  // busy reads as set in reset so the nets stay held
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      busy_meta_reg <= `BUSY_RESET;
      busy_sync_reg <= `BUSY_RESET;
    end else begin
      busy_meta_reg <= config_busy_i;
      busy_sync_reg <= busy_meta_reg;
    end
  end

  // user set/reset source, brought onto sys_clk_i
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      usr_sr_meta_reg <= `SYNC_RESET;
      usr_sr_sync_reg <= `SYNC_RESET;
    end else begin
      usr_sr_meta_reg <= user_set_reset_i;
      usr_sr_sync_reg <= usr_sr_meta_reg;
    end
  end

  // user high-z source
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      usr_hz_meta_reg <= `SYNC_RESET;
      usr_hz_sync_reg <= `SYNC_RESET;
    end else begin
      usr_hz_meta_reg <= user_high_z_i;
      usr_hz_sync_reg <= usr_hz_meta_reg;
    end
  end

  // shared slice input, one per slice
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      slice_sr_meta_reg <= `SYNC_RESET;
      slice_sr_sync_reg <= `SYNC_RESET;
    end else begin
      slice_sr_meta_reg <= set_reset_input_i;
      slice_sr_sync_reg <= slice_sr_meta_reg;
    end
  end

  // per-lane data inputs
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      data_meta_reg <= {SLICE_W{`SYNC_RESET}};
      data_sync_reg <= {SLICE_W{`SYNC_RESET}};
    end else begin
      data_meta_reg <= latch_data_input_i;
      data_sync_reg <= data_meta_reg;
    end
  end

  // state decode
  assign in_config   = (state_reg == S_CONFIG);
  assign in_startup  = (state_reg == S_STARTUP);
  assign in_user     = (state_reg == S_USER);
  assign release_hit = in_startup && (cyc_reg == REL_CYCLE);

  // busy during start-up aborts the count, so no early release
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_CONFIG: begin
        if (!busy_sync_reg) begin
          state_next = S_STARTUP;
        end
      end
      S_STARTUP: begin
        if (busy_sync_reg) begin
          state_next = S_CONFIG;
        end else if (release_hit) begin
          state_next = S_USER;
        end
      end
      S_USER: begin
        if (busy_sync_reg) begin
          state_next = S_CONFIG;
        end
      end
      default: begin
        state_next = S_CONFIG;
      end
    endcase
  end

  // start-up cycle counter, cleared outside start-up
  always @* begin
    if (in_startup) begin
      cyc_next = cyc_reg + `CYC_STEP;
    end else begin
      cyc_next = `CYC_ZERO;
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= S_CONFIG;
    end else begin
      state_reg <= state_next;
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      cyc_reg <= `CYC_ZERO;
    end else begin
      cyc_reg <= cyc_next;
    end
  end

  // set/reset held until the user state, then user driven
  always @* begin
    if (!in_user) begin
      net_sr_src = `NET_HELD;
    end else begin
      net_sr_src = usr_sr_sync_reg;
    end
  end

  // high-z held until the user state, then user driven
  always @* begin
    if (!in_user) begin
      net_hz_src = `NET_HELD;
    end else begin
      net_hz_src = usr_hz_sync_reg;
    end
  end

  // latch gates: clock and enable held on, so plain logic
  generate
    for (lane = 0; lane < SLICE_W; lane = lane + 1) begin : gate_lane
      assign and_inv_out[lane] = slice_sr_sync_reg & ~data_sync_reg[lane];
      assign or_out[lane]      = data_sync_reg[lane] | slice_sr_sync_reg;
    end
  endgenerate

  // per-lane choice of gate kind
  always @* begin
    gate_next = {SLICE_W{`GATE_INIT}};
    for (bit_idx = 0; bit_idx < SLICE_W; bit_idx = bit_idx + 1) begin
      if (gate_is_or_i[bit_idx]) begin
        gate_next[bit_idx] = or_out[bit_idx];
      end else begin
        gate_next[bit_idx] = and_inv_out[bit_idx];
      end
    end
  end

  // gates sit at a known value while set/reset is high
  always @* begin
    if (net_sr_src) begin
      gate_q_next = {SLICE_W{`GATE_INIT}};
    end else begin
      gate_q_next = gate_next;
    end
  end

  // each die gets its own copy of one source, no die-to-die chain
  always @* begin
    sr_net_next = {NUM_DIES{`NET_HELD}};
    for (die_idx = 0; die_idx < NUM_DIES; die_idx = die_idx + 1) begin
      sr_net_next[die_idx] = net_sr_src;
    end
  end

  always @* begin
    hz_net_next = {NUM_DIES{`NET_HELD}};
    for (die_idx = 0; die_idx < NUM_DIES; die_idx = die_idx + 1) begin
      hz_net_next[die_idx] = net_hz_src;
    end
  end

  // ready mirrors the release so user logic can gate key flops
  always @* begin
    ready_next = ~net_sr_src;
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      global_set_reset_net_o <= {NUM_DIES{`NET_HELD}};
    end else begin
      global_set_reset_net_o <= sr_net_next;
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      global_high_z_net_o <= {NUM_DIES{`NET_HELD}};
    end else begin
      global_high_z_net_o <= hz_net_next;
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      gate_q_o <= {SLICE_W{`GATE_INIT}};
    end else begin
      gate_q_o <= gate_q_next;
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      user_ready_o <= `READY_INIT;
    end else begin
      user_ready_o <= ready_next;
    end
  end

endmodule // global_reset_tristate_control

// ---- sim/cfg_model.sv ----
`timescale 1ns/1ns
module cfg_model (input wire sys_clk_i, input wire start_i, output reg busy_o = 1'h1);
  reg [3:0] cnt_reg = 4'h8;
  always @(posedge sys_clk_i) begin
    cnt_reg <= start_i ? 4'h8 : cnt_reg - (|cnt_reg);
    busy_o <= start_i | (|cnt_reg);
  end
endmodule // cfg_model

// ---- sim/grc_checker.sv ----
`timescale 1ns/1ns
module grc_chk #(parameter NUM_DIES = 2, SLICE_W = 4) (input wire sys_clk_i, reset_i, config_busy_i,
  user_set_reset_i, user_high_z_i, set_reset_input_i, user_ready_o,
  input wire [SLICE_W-1:0] latch_data_input_i, gate_is_or_i, gate_q_o,
  input wire [NUM_DIES-1:0] global_set_reset_net_o, global_high_z_net_o);
  wire g = global_set_reset_net_o[0], h = global_high_z_net_o[0];
  wire [SLICE_W-1:0] s = {SLICE_W{set_reset_input_i}}, d = latch_data_input_i, m = gate_is_or_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_free; !g [*4]; endsequence
  a_dies_alike: assert property (global_set_reset_net_o == {NUM_DIES{g}}) else $error("die copy");
  a_gate_clear: assert property (g |-> gate_q_o == 0) else $error("gate set");
  a_busy_forces: assert property (config_busy_i [*2] |-> ##[0:3] g && h) else $error("busy");
  a_sr_fall: assert property ($fell(g) |-> !$past(user_set_reset_i, 3)) else $error("sr fall");
  a_sr_rise: assert property ($rose(g) |-> $past(user_set_reset_i, 3) || $past(config_busy_i, 4)) else $error("sr");
  a_hz_fall: assert property ($fell(h) |-> !$past(user_high_z_i, 3)) else $error("hz fall");
  a_ready_tie: assert property (user_ready_o |-> !g) else $error("ready");
  a_gate_func: assert property (s_free |-> gate_q_o == ($past(m) & ($past(d, 3) | $past(s, 3))
    | ~$past(m) & $past(s, 3) & ~$past(d, 3))) else $error("gate");
endmodule // grc_chk
bind global_reset_tristate_control grc_chk #(.NUM_DIES(NUM_DIES), .SLICE_W(SLICE_W)) u_chk (.*);

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  reg sys_clk_i = 0, reset_i = 1, user_set_reset_i = 0, user_high_z_i = 0, set_reset_input_i = 0, go = 0;
  reg [3:0] latch_data_input_i = 0, gate_is_or_i = 4'h5;
  wire config_busy_i, user_ready_o;
  wire [1:0] global_set_reset_net_o, global_high_z_net_o;
  wire [3:0] gate_q_o, v = {4{set_reset_input_i}}, d = latch_data_input_i, m = gate_is_or_i;
  wire [4:0] n = {global_set_reset_net_o, global_high_z_net_o, user_ready_o};
  integer error_cnt = 0, n_checks = 0, i;
  cfg_model ptr (.sys_clk_i, .start_i(go), .busy_o(config_busy_i));
  global_reset_tristate_control dut (.*);
  initial forever #5 sys_clk_i = ~sys_clk_i;
  task chk(input [8:0] s, e);
    n_checks++;
    if (s !== e) $display("MISMATCH %0t value differs", $time);
    error_cnt += s !== e;
  endtask
  task wrap_up;
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task t_release;
    @(negedge config_busy_i);
    for (i = 0; i < 20 && n[4]; i++) @(posedge sys_clk_i) #1;
    chk(i > 5 && i < 11, 1);
    chk(n, 1);
  endtask
  task t_user;
    for (i = 3; i >= 0; i--) begin
      @(posedge sys_clk_i) {user_set_reset_i, user_high_z_i} <= i[1:0];
      repeat (5) @(posedge sys_clk_i) #1;
      chk(n, {{2{i[1]}}, {2{i[0]}}, !i[1]});
    end
  endtask
  task t_gates;
    for (i = 0; i < 32; i++) begin
      @(posedge sys_clk_i) {set_reset_input_i, latch_data_input_i} <= i[4:0];
      repeat (4) @(posedge sys_clk_i) #1;
      chk(gate_q_o, m & (d | v) | ~m & v & ~d);
    end
  endtask
  task t_reconf;
    @(posedge sys_clk_i) go <= 1;
    @(posedge sys_clk_i) go <= 0;
    repeat (5) @(posedge sys_clk_i) #1;
    chk({n[4:1], gate_q_o, n[0]}, 9'h1e0);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 0;
    t_release;
    t_user;
    t_gates;
    t_reconf;
    wrap_up;
  end
  // roughly ten times the expected run
  initial begin
    #20000;
    error_cnt++;
    wrap_up;
  end
endmodule // tb_top
